// [core/isp_apb_slave.sv]
// APB slave front end that answers each transfer in its first access cycle.
`timescale 1ns/1ps
module isp_apb_slave
  import isp_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  input  wire isp_pkg::isp_apb_req_t apb_req_i,
  input  wire logic [31:0]           rdata_i,
  output isp_pkg::isp_apb_rsp_t      apb_rsp_o
);
  import isp_pkg::*;

  isp_apb_rsp_t rsp_r;
  isp_apb_rsp_t rsp_nxt;

  // Read data, error and ready are latched together in the setup cycle and show one cycle later.
  always_comb
  begin
    rsp_nxt = '0;
    if (apb_req_i.psel && !apb_req_i.penable)
    begin
      rsp_nxt.pready  = 1'b1;
      rsp_nxt.pslverr = !isp_mapped(apb_req_i.paddr);
      rsp_nxt.prdata  = (apb_req_i.pwrite || !isp_mapped(apb_req_i.paddr)) ? 32'h0 : rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      rsp_r <= '0;
    else
      rsp_r <= rsp_nxt;
  end

  assign apb_rsp_o = rsp_r;

endmodule

// [core/isp_bank.sv]
// Interrupt force-pending bank for lines 0 to 31 except five, with clear bank, events and APB access.
//
// Operation
// R1 - Writing one pends the interrupt; zero ignored.
// R2 - One to pending or disabled interrupt: no effect.
// R3 - Read returns live pending state per interrupt.
// R4 - Clear-pending write one clears the pending bit.
// R5 - Bit n maps to interrupt n, except five.
// R6 - Software writes zero to reserved bit five.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module isp_bank
  import isp_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  input  wire isp_pkg::isp_apb_req_t apb_req_i,
  output isp_pkg::isp_apb_rsp_t      apb_rsp_o,
  input  wire logic [31:0]           irq_enable_i,
  input  wire logic [31:0]           irq_line_i,
  output logic [31:0]                force_pending_bit_o,
  output logic                       irq_o
);
  import isp_pkg::*;

  typedef struct packed {
    logic [31:0]        pending;
    logic [ISP_NEV-1:0] ev_stat;
    logic [ISP_NEV-1:0] ev_mask;
    logic               irq;
  } isp_state_t;

  isp_state_t  st_r;
  isp_state_t  st_nxt;
  logic [31:0] rdata_w;
  logic        wr_force_w;
  logic        wr_clear_w;
  logic        wr_stat_w;
  logic        wr_mask_w;
  logic [31:0] force_set_w;
  logic [31:0] force_void_w;
  logic [31:0] clr_w;
  logic [31:0] hw_set_w;

  isp_apb_slave u_apb
  (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .apb_req_i (apb_req_i),
    .rdata_i   (rdata_w),
    .apb_rsp_o (apb_rsp_o)
  );

  assign wr_force_w = isp_wr_to(apb_req_i, apb_rsp_o.pready, ISP_OFF_FORCE);
  assign wr_clear_w = isp_wr_to(apb_req_i, apb_rsp_o.pready, ISP_OFF_CLEAR);
  assign wr_stat_w  = isp_wr_to(apb_req_i, apb_rsp_o.pready, ISP_OFF_STAT);
  assign wr_mask_w  = isp_wr_to(apb_req_i, apb_rsp_o.pready, ISP_OFF_MASK);

  // Only enabled, not yet pending, existing lines can be forced.
  assign force_set_w  = wr_force_w ? (apb_req_i.pwdata & irq_enable_i & ~st_r.pending &
                                      ISP_VALID_BITS) : 32'h0; // R1 R2 R5 R6
  assign force_void_w = wr_force_w ? (apb_req_i.pwdata & ISP_VALID_BITS & ~force_set_w)
                                   : 32'h0; // R2
  assign clr_w        = wr_clear_w ? (apb_req_i.pwdata & ISP_VALID_BITS) : 32'h0; // R4
  assign hw_set_w     = irq_line_i & ISP_VALID_BITS; // R5

  // Both pending banks read the live state; bit five always reads zero.
  always_comb
  begin
    rdata_w = 32'h0;
    unique case (apb_req_i.paddr)
      ISP_OFF_FORCE: rdata_w = st_r.pending & ISP_VALID_BITS; // R3
      ISP_OFF_CLEAR: rdata_w = st_r.pending & ISP_VALID_BITS; // R3
      ISP_OFF_STAT:  rdata_w = {{(32-ISP_NEV){1'b0}}, st_r.ev_stat};
      ISP_OFF_MASK:  rdata_w = {{(32-ISP_NEV){1'b0}}, st_r.ev_mask};
      default:       rdata_w = 32'h0;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    // A set in the same cycle as a clear wins.
    st_nxt.pending = ((st_r.pending & ~clr_w) | force_set_w | hw_set_w) &
                     ISP_VALID_BITS; // R1 R4 R6
    if (wr_mask_w)
      st_nxt.ev_mask = apb_req_i.pwdata[ISP_NEV-1:0];
    if (wr_stat_w)
      st_nxt.ev_stat = st_r.ev_stat & ~apb_req_i.pwdata[ISP_NEV-1:0];
    if (|force_set_w)
      st_nxt.ev_stat[ISP_EV_ACCEPT] = 1'b1;
    if (|force_void_w)
      st_nxt.ev_stat[ISP_EV_IGNORED] = 1'b1;
    st_nxt.irq = |(st_nxt.ev_stat & st_nxt.ev_mask);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      st_r.pending <= ISP_PEND_RST;
      st_r.ev_stat <= ISP_EV_RST;
      st_r.ev_mask <= ISP_EV_RST;
      st_r.irq     <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign force_pending_bit_o = st_r.pending;
  assign irq_o               = st_r.irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  AST_FORCE_SETS: assert property ( // R1
    |force_set_w |=> ((st_r.pending & $past(force_set_w)) == $past(force_set_w)))
    else $error("Forced interrupt did not become pending.");

  AST_ZERO_KEEPS: assert property ( // R1
    (wr_force_w && !wr_clear_w && hw_set_w == 32'h0) |=>
      (((st_r.pending ^ $past(st_r.pending)) & ~$past(force_set_w)) == 32'h0))
    else $error("Pending bit changed without a one written for it.");

  AST_DISABLED_NOEFFECT: assert property ( // R2
    (wr_force_w && !wr_clear_w && hw_set_w == 32'h0) |=>
      ((st_r.pending & ~$past(st_r.pending) & ~$past(irq_enable_i)) == 32'h0))
    else $error("Disabled interrupt was forced pending.");

  AST_READ_PENDING: assert property ( // R3
    (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite &&
     apb_req_i.paddr == ISP_OFF_FORCE) |=>
      (apb_rsp_o.pready && apb_rsp_o.prdata == $past(st_r.pending)))
    else $error("Read data does not match pending state.");

  AST_CLEAR: assert property ( // R4
    |clr_w |=> ((st_r.pending & $past(clr_w) & ~$past(hw_set_w) &
                 ~$past(force_set_w)) == 32'h0))
    else $error("Clear-pending write left a bit set.");

  AST_RESERVED_ZERO: assert property ( // R5
    !st_r.pending[5] && !apb_rsp_o.prdata[5])
    else $error("Reserved position five shows pending.");

  AST_IRQ_LEVEL: assert property (
    irq_o == |(st_r.ev_stat & st_r.ev_mask))
    else $error("Interrupt output disagrees with masked status.");

  AST_READY_ONE_CYCLE: assert property (
    (apb_req_i.psel && !apb_req_i.penable) |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
    else $error("Ready did not pulse for exactly one cycle.");

  AST_HW_SETS: assert property (
    |hw_set_w |=> ((st_r.pending & $past(hw_set_w)) == $past(hw_set_w)))
    else $error("Hardware line did not set its pending bit.");

  AST_NO_SPURIOUS_SET: assert property ( // R1
    1'b1 |=> ((st_r.pending & ~$past(st_r.pending) & ~$past(force_set_w) &
               ~$past(hw_set_w)) == 32'h0))
    else $error("Pending bit rose without a force or a line.");

  AST_NO_SPURIOUS_CLEAR: assert property ( // R4
    1'b1 |=> ((~st_r.pending & $past(st_r.pending) & ~$past(clr_w)) == 32'h0))
    else $error("Pending bit fell without a clear.");

  AST_ACCEPT_EVENT: assert property (
    |force_set_w |=> st_r.ev_stat[ISP_EV_ACCEPT])
    else $error("Accepted force did not set its status bit.");

  AST_VOID_EVENT: assert property ( // R2
    |force_void_w |=> st_r.ev_stat[ISP_EV_IGNORED])
    else $error("Ignored force did not set its status bit.");

  AST_STAT_W1C: assert property (
    wr_stat_w |=> ({{(32-ISP_NEV){1'b0}}, st_r.ev_stat} ==
                   ({{(32-ISP_NEV){1'b0}}, $past(st_r.ev_stat)} & ~$past(apb_req_i.pwdata))))
    else $error("Status write did not clear the bits written with one.");

  AST_MASK_WRITE: assert property (
    wr_mask_w |=> ({{(32-ISP_NEV){1'b0}}, st_r.ev_mask} ==
                   ($past(apb_req_i.pwdata) & {{(32-ISP_NEV){1'b0}}, {ISP_NEV{1'b1}}})))
    else $error("Mask write did not take the written value.");

  AST_SLVERR: assert property (
    (apb_req_i.psel && !apb_req_i.penable && !isp_mapped(apb_req_i.paddr)) |=>
      apb_rsp_o.pslverr)
    else $error("Unmapped access was not answered with an error.");

  AST_NO_SLVERR: assert property (
    (apb_req_i.psel && !apb_req_i.penable && isp_mapped(apb_req_i.paddr)) |=>
      !apb_rsp_o.pslverr)
    else $error("Mapped access was answered with an error.");

  AST_WRITE_DATA_ZERO: assert property (
    (apb_req_i.psel && !apb_req_i.penable && apb_req_i.pwrite) |=>
      (apb_rsp_o.prdata == 32'h0))
    else $error("Write transfer returned nonzero read data.");

  AST_READ_CLEAR_BANK: assert property ( // R3
    (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite &&
     apb_req_i.paddr == ISP_OFF_CLEAR) |=>
      (apb_rsp_o.pready && apb_rsp_o.prdata == $past(st_r.pending)))
    else $error("Clear bank read does not match pending state.");

  AST_UNMAPPED_NO_WRITE: assert property (
    (apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite &&
     !isp_mapped(apb_req_i.paddr) && hw_set_w == 32'h0) |=> (st_r == $past(st_r)))
    else $error("Unmapped write changed the bank state.");

  AST_READY_IDLE: assert property (
    !apb_req_i.psel |=> !apb_rsp_o.pready)
    else $error("Ready rose without a transfer.");

  COV_SET_WINS: cover property (|(clr_w & hw_set_w));
  COV_FORCE: cover property (wr_force_w && |force_set_w);
  COV_CLEAR: cover property (wr_clear_w ##1 (st_r.pending == 32'h0));
  COV_IRQ:   cover property (!irq_o ##1 irq_o);
  COV_VOID:  cover property (wr_force_w && |force_void_w);

endmodule

// [include/isp_pkg.sv]
// Package with offsets, reset values, carrier types and decode helpers for the bank.
package isp_pkg;

  localparam int unsigned ISP_AW          = 12;
  localparam int unsigned ISP_DW          = 32;
  localparam int unsigned ISP_NEV         = 2;
  localparam logic [11:0] ISP_OFF_FORCE   = 12'h000;
  localparam logic [11:0] ISP_OFF_CLEAR   = 12'h004;
  localparam logic [11:0] ISP_OFF_STAT    = 12'h008;
  localparam logic [11:0] ISP_OFF_MASK    = 12'h00c;
  localparam logic [31:0] ISP_VALID_BITS  = 32'hffff_ffdf;
  localparam logic [31:0] ISP_PEND_RST    = 32'h0000_0000;
  localparam logic [1:0]  ISP_EV_RST      = 2'h0;
  localparam int unsigned ISP_EV_ACCEPT   = 0;
  localparam int unsigned ISP_EV_IGNORED  = 1;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } isp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } isp_apb_rsp_t;

  // Returns one when the byte address selects a register of the bank.
  function automatic logic isp_mapped(input logic [11:0] addr);
    return (addr == ISP_OFF_FORCE) || (addr == ISP_OFF_CLEAR) ||
           (addr == ISP_OFF_STAT)  || (addr == ISP_OFF_MASK);
  endfunction

  // Returns one when a completed write targets the given offset.
  function automatic logic isp_wr_to(input isp_apb_req_t req, input logic ready,
                                     input logic [11:0] off);
    return req.psel && req.penable && req.pwrite && ready && (req.paddr == off);
  endfunction

endpackage

// [tb/test_isp_bank.sv]
// Self-checking bench for the interrupt force-pending bank.
`timescale 1ns/1ps
module test_isp_bank import isp_pkg::*;;
  logic         clk_sys_i = 1'b0;
  logic         reset_i   = 1'b1;
  isp_apb_req_t req       = '0;
  isp_apb_rsp_t rsp;
  logic [31:0]  en        = 32'hffff_ffff;
  logic [31:0]  hw        = 32'h0000_0000;
  logic [31:0]  pend;
  logic         irq;
  logic [31:0]  rdat;
  logic         rerr;
  int           n_errors  = 0;
  int           checked   = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  isp_bank dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .irq_enable_i(en), .irq_line_i(hw), .force_pending_bit_o(pend), .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge where pready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 100);
    if (rsp.pready !== 1'b1)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, rsp.pready, 1'b1);
      finish_test();
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask

  task automatic finish_test();
    $display("Errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    apb(1'b0, ISP_OFF_FORCE, '0);
    chk(rdat, ISP_PEND_RST);
    // Each bit alone pends its own line only; the reserved position is written with zero.
    for (int n = 0; n < 32; n++)
    begin
      apb(1'b1, ISP_OFF_FORCE, (n == 5) ? 32'h0 : 32'h1 << n);
      @(posedge clk_sys_i);
      chk(pend, (n == 5) ? 32'h0 : 32'h1 << n);
      apb(1'b1, ISP_OFF_CLEAR, (n == 5) ? 32'h0 : 32'h1 << n);
      apb(1'b0, ISP_OFF_FORCE, '0);
      chk(rdat, 32'h0);
    end
    apb(1'b1, ISP_OFF_STAT, 32'h3);
    en <= ~32'h2;
    apb(1'b1, ISP_OFF_FORCE, 32'h6);
    apb(1'b0, ISP_OFF_STAT, '0);
    chk(rdat, 32'h3);
    apb(1'b1, ISP_OFF_FORCE, 32'h0);
    apb(1'b0, ISP_OFF_FORCE, '0);
    chk(rdat, 32'h4);
    apb(1'b1, ISP_OFF_STAT, 32'h3);
    apb(1'b1, ISP_OFF_MASK, 32'h1);
    apb(1'b1, ISP_OFF_FORCE, 32'h4);
    apb(1'b0, ISP_OFF_STAT, '0);
    chk(rdat, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ISP_OFF_FORCE, 32'h1);
    @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ISP_OFF_STAT, 32'h1);
    @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, ISP_OFF_MASK, '0);
    chk(rdat, 32'h1);
    apb(1'b1, ISP_OFF_CLEAR, 32'h5);
    apb(1'b0, ISP_OFF_CLEAR, '0);
    chk(rdat, 32'h0);
    hw <= 32'h8000_0000;
    @(posedge clk_sys_i);
    hw <= 32'h0;
    apb(1'b0, ISP_OFF_FORCE, '0);
    chk(rdat, 32'h8000_0000);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, ISP_OFF_FORCE, '0);
    chk(rdat, 32'h8000_0000);
    hw <= 32'h8000_0000;
    apb(1'b1, ISP_OFF_CLEAR, 32'h8000_0000);
    hw <= 32'h0;
    apb(1'b0, ISP_OFF_FORCE, '0);
    chk(rdat, 32'h8000_0000);
    apb(1'b1, ISP_OFF_CLEAR, 32'h8000_0000);
    apb(1'b0, ISP_OFF_FORCE, '0);
    chk(rdat, 32'h0);
    finish_test();
  end

  // Cuts a hang short well after the sequence should have ended.
  initial
  begin
    #40000;
    n_errors++;
    finish_test();
  end
endmodule
